// >>> rtl/ssq_engine.sv
// What this block does
// - up to 63 programmable state definitions, each addressed by state number
// - every state observes all eight supervised fault detector results
// - any programmed state may name any other state as next state
// - three exits per state: sequence, monitor fault and timeout
// - sequence and timeout delays independent, reloaded on each state change, up to 400 ms
// - eight driver levels fixed per state, unchanged while in that state
// - transition including definition fetch completes under 20 us
// - a flagged state triggers a black box record write on entry
// - converter and secondary monitor warnings ORed into monitor and timeout detectors, selectable as sequence input
// - host jump acts through timeout detector, forcing sequence next state
// - sequence detector watches one selected input for its programmed level
// - sequence delay programmable 10 us to 400 ms as qualification
// - watched input must hold for whole delay; any change restarts timer
// - monitor detector is wide OR of selected inputs deviating from expected
// - monitor exit has no delay; only fetch latency before new state
// - timeout exit when condition absent within 100 us to 400 ms delay
// - engine-sourced driver outputs take new state levels immediately on entry
// - detector exits allow watchdog programs on a toggling clock input
// - reference program: rail A enable to rail A off if supply two bad at 10 ms
// - each driver output selects engine, host value or internal 100 kHz clock
// - dual function digital inputs feed the engine as conditions
`timescale 1ns/10ps
module ssq_engine
    import ssq_pkg::*;
#(
    parameter int unsigned FETCH_LAT = 16
) (
    input  wire logic                            CLK,          // 250 MHz clock
    input  wire logic                            RST_B,        // async reset, low
    input  wire logic [2:0]                      POS_SUPPLY_OK, // supply fault detector, rails 1-3
    input  wire logic                            HV_OK,        // high voltage input ok
    input  wire logic [3:0]                      DUAL_IN,      // dual function inputs
    input  wire logic                            LIMIT_WARN,   // converter limit warning
    input  wire logic [3:0]                      SEC_WARN,     // secondary monitor warnings
    input  wire logic                            JUMP,         // host jump pulse
    output logic      [STATE_W-1:0]              DEF_ADDR,     // definition fetch address
    output logic                                 DEF_REQ,      // fetch request level
    input  wire logic                            DEF_VALID,    // definition returned
    input  wire ssq_pkg::ssq_def_t               DEF_DATA,     // state definition
    input  wire ssq_pkg::ssq_src_t [NUM_DRV-1:0] DRV_SRC,      // per-output source select
    input  wire logic [NUM_DRV-1:0]              DRV_HOST,     // host driven levels
    output logic      [NUM_DRV-1:0]              DRIVER_OUTPUT, // driver output levels
    output logic      [STATE_W-1:0]              CUR_STATE,    // current state number
    output logic                                 BBOX_WR,      // black box write pulse
    output ssq_pkg::ssq_rec_t                    BBOX_REC,     // black box record
    output logic                                 FETCH_ERR     // sticky fetch overrun
);
    import ssq_pkg::*;

    if (FETCH_LAT == 0 || FETCH_LAT >= FETCH_MAX_CYC) begin : g_bad_lat
        $error("FETCH_LAT out of range");
    end

    typedef enum logic [1:0] {S_FETCH, S_ARM, S_RUN} ssq_st_t;

    // fetch watch must count past the 20 us limit
    localparam int unsigned FC_W = $clog2(FETCH_MAX_CYC + 1);

    ssq_st_t            st_q;
    ssq_def_t           def_q;
    logic [STATE_W-1:0] cur_q, next_d;
    logic [NUM_IN-1:0]  in_raw, in_s;
    logic [3:0]         sec_s;
    logic               lim_s, warn;
    logic               jump_q;
    logic [CK_W-1:0]    tick_cnt_q;
    logic               tick;
    logic [CK_W-1:0]    ck_cnt_q;
    logic               clk100k_q;
    logic [NUM_DRV-1:0] drv_lvl_q;
    logic [FC_W-1:0]    fetch_cnt_q;
    logic               seq_hit, seq_hit_q, seq_done, tmo_done, mon_hit;
    logic               seq_exit, tmo_exit, mon_exit;
    ssq_exit_t          cause_d;

    assign in_raw = {DUAL_IN, HV_OK, POS_SUPPLY_OK};
    ssq_sync #(.W(NUM_IN)) u_sync_in (
        .CLK   (CLK),
        .RST_B (RST_B),
        .D     (in_raw),
        .Q     (in_s)
    );
    ssq_sync #(.W(5)) u_sync_warn (
        .CLK   (CLK),
        .RST_B (RST_B),
        .D     ({LIMIT_WARN, SEC_WARN}),
        .Q     ({lim_s, sec_s})
    );
    assign warn = lim_s | (|sec_s);

    // timebase for delay timers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick = (tick_cnt_q == CK_W'(TICK_CYC - 1));

    // internal 100 kHz clock
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ck_cnt_q  <= '0;
            clk100k_q <= 1'b0;
        end else if (ck_cnt_q == CK_W'(CLK100K_HALF - 1)) begin
            ck_cnt_q  <= '0;
            clk100k_q <= ~clk100k_q;
        end else begin
            ck_cnt_q <= ck_cnt_q + 1'b1;
        end
    end

    // host jump held until the engine can act on it
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            jump_q <= 1'b0;
        end else if (JUMP) begin
            jump_q <= 1'b1;
        end else if (st_q == S_RUN) begin
            jump_q <= 1'b0;
        end
    end

    function automatic logic sel_in(input logic [3:0] sel, input logic [NUM_IN-1:0] v,
                                    input logic w);
        if (sel == SEL_WARN) begin
            return w;
        end else if (sel < 4'(NUM_IN)) begin
            return v[sel[2:0]];
        end
        return 1'b0;
    endfunction

    // sequence: selected input at target level
    assign seq_hit = (def_q.seq_sel != SEL_JUMP_ONLY) &&
                     (sel_in(def_q.seq_sel, in_s, warn) == def_q.seq_pol);
    // monitor: wide OR of deviating inputs
    assign mon_hit = (|(def_q.mon_mask & (in_s ^ def_q.mon_pol))) |
                     (def_q.mon_warn & warn);

    ssq_timer #(.W(DLY_W)) u_seq_tmr (
        .CLK   (CLK),
        .RST_B (RST_B),
        .TICK  (tick),
        .LOAD  ((st_q == S_ARM) || (seq_hit != seq_hit_q)),
        .DLY   (def_q.seq_dly),
        .DONE  (seq_done)
    );
    ssq_timer #(.W(DLY_W)) u_tmo_tmr (
        .CLK   (CLK),
        .RST_B (RST_B),
        .TICK  (tick),
        .LOAD  (st_q == S_ARM),
        .DLY   (def_q.tmo_dly),
        .DONE  (tmo_done)
    );

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            seq_hit_q <= 1'b0;
        end else begin
            seq_hit_q <= seq_hit;
        end
    end

    assign mon_exit = (st_q == S_RUN) && mon_hit;
    assign tmo_exit = (st_q == S_RUN) && ((def_q.tmo_en && tmo_done) ||
                      (def_q.tmo_warn && warn) || jump_q);
    assign seq_exit = (st_q == S_RUN) && seq_hit && seq_hit_q && seq_done;

    // exit priority
    always_comb begin
        next_d  = cur_q;
        cause_d = EXIT_NONE;
        if (mon_exit) begin
            next_d  = def_q.mon_next;
            cause_d = EXIT_MON;
        end else if (tmo_exit) begin
            next_d  = jump_q ? def_q.seq_next : def_q.tmo_next;
            cause_d = EXIT_TMO;
        end else if (seq_exit) begin
            next_d  = def_q.seq_next;
            cause_d = EXIT_SEQ;
        end
    end

    // state engine
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_q  <= S_FETCH;
            cur_q <= RESET_STATE;
            def_q <= '0;
        end else begin
            unique case (st_q)
                S_FETCH: begin
                    if (DEF_VALID) begin
                        def_q <= DEF_DATA;
                        st_q  <= S_ARM;
                    end
                end
                S_ARM: begin
                    st_q <= S_RUN;
                end
                S_RUN: begin
                    if (cause_d != EXIT_NONE) begin
                        cur_q <= (next_d < STATE_W'(NUM_STATES)) ? next_d : RESET_STATE;
                        st_q  <= S_FETCH;
                    end
                end
            endcase
        end
    end

    // fetch latency watch
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            fetch_cnt_q <= '0;
            FETCH_ERR   <= 1'b0;
        end else if (st_q != S_FETCH) begin
            fetch_cnt_q <= '0;
        end else begin
            fetch_cnt_q <= fetch_cnt_q + 1'b1;
            if (fetch_cnt_q == FC_W'(FETCH_MAX_CYC - 2)) begin
                FETCH_ERR <= 1'b1;
            end
        end
    end

    // driver levels latched once per state
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            drv_lvl_q <= '0;
        end else if (st_q == S_FETCH && DEF_VALID) begin
            drv_lvl_q <= DEF_DATA.drv_level;
        end
    end

    // black box write on entry to a flagged state; record captured on every exit
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            BBOX_WR  <= 1'b0;
            BBOX_REC <= '0;
        end else begin
            BBOX_WR <= (st_q == S_FETCH) && DEF_VALID && DEF_DATA.bbox_wr;
            if (st_q == S_RUN && cause_d != EXIT_NONE) begin
                BBOX_REC <= '{prev_state: cur_q, cause: cause_d, status: in_s};
            end
        end
    end

    // per-output source
    generate
        for (genvar i = 0; i < NUM_DRV; i++) begin : g_drv
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    DRIVER_OUTPUT[i] <= 1'b0;
                end else begin
                    unique case (DRV_SRC[i])
                        SRC_FSM:  DRIVER_OUTPUT[i] <= drv_lvl_q[i];
                        SRC_HOST: DRIVER_OUTPUT[i] <= DRV_HOST[i];
                        SRC_CLK:  DRIVER_OUTPUT[i] <= clk100k_q;
                        default:  DRIVER_OUTPUT[i] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    assign DEF_ADDR  = cur_q;
    assign DEF_REQ   = (st_q == S_FETCH);
    assign CUR_STATE = cur_q;

    property p_prio;
        @(posedge CLK) disable iff (!RST_B)
        (mon_exit && (tmo_exit || seq_exit)) |=> (cur_q == $past(def_q.mon_next)
            || $past(def_q.mon_next) >= STATE_W'(NUM_STATES));
    endproperty
    a_prio: assert property (p_prio) else $error("monitor exit lost priority");

    property p_mon_fast;
        @(posedge CLK) disable iff (!RST_B)
        mon_exit |=> (st_q == S_FETCH);
    endproperty
    a_mon_fast: assert property (p_mon_fast) else $error("monitor exit delayed");

    property p_drv_stable;
        @(posedge CLK) disable iff (!RST_B)
        (st_q == S_RUN && $past(st_q) == S_RUN) |->
            ($stable(drv_lvl_q) && drv_lvl_q == def_q.drv_level);
    endproperty
    a_drv_stable: assert property (p_drv_stable) else $error("levels moved in state");

    property p_arm;
        @(posedge CLK) disable iff (!RST_B)
        (st_q == S_FETCH && DEF_VALID) |=> (st_q == S_ARM) ##1 (st_q == S_RUN);
    endproperty
    a_arm: assert property (p_arm) else $error("exit armed before load");

    property p_bbox;
        @(posedge CLK) disable iff (!RST_B)
        (st_q == S_FETCH && DEF_VALID && DEF_DATA.bbox_wr) |=> BBOX_WR;
    endproperty
    a_bbox: assert property (p_bbox) else $error("black box write missed");

    property p_jump;
        @(posedge CLK) disable iff (!RST_B)
        (st_q == S_RUN && jump_q && !mon_exit) |=> (st_q == S_FETCH);
    endproperty
    a_jump: assert property (p_jump) else $error("jump not taken");

    property p_fsm_src;
        @(posedge CLK) disable iff (!RST_B)
        (DRV_SRC[0] == SRC_FSM) |=> (DRIVER_OUTPUT[0] == $past(drv_lvl_q[0]));
    endproperty
    a_fsm_src: assert property (p_fsm_src) else $error("driver source wrong");

    property p_fetch;
        @(posedge CLK) disable iff (!RST_B)
        (st_q == S_FETCH && DEF_VALID) |-> (fetch_cnt_q < FC_W'(FETCH_MAX_CYC));
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch too slow");
endmodule

// >>> rtl/ssq_pkg.sv
package ssq_pkg;
    localparam int unsigned CLK_HZ        = 250_000_000;
    localparam int unsigned NUM_STATES    = 63;
    localparam int unsigned STATE_W       = 6;
    localparam int unsigned NUM_IN        = 8;
    localparam int unsigned NUM_DRV       = 8;
    localparam int unsigned TICK_US       = 10;
    localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned DLY_MAX_MS    = 400;
    localparam int unsigned DLY_MAX_TICKS = DLY_MAX_MS * 1000 / TICK_US;
    localparam int unsigned DLY_W         = 16;
    localparam int unsigned SEQ_MIN_US    = 10;
    localparam int unsigned SEQ_MIN_TICKS = SEQ_MIN_US / TICK_US;
    localparam int unsigned TMO_MIN_US    = 100;
    localparam int unsigned TMO_MIN_TICKS = TMO_MIN_US / TICK_US;
    localparam int unsigned FETCH_MAX_US  = 20;
    localparam int unsigned FETCH_MAX_CYC = CLK_HZ / 1_000_000 * FETCH_MAX_US;
    localparam int unsigned CLK100K_HZ    = 100_000;
    localparam int unsigned CLK100K_HALF  = CLK_HZ / CLK100K_HZ / 2;
    localparam int unsigned CK_W          = 12;
    localparam logic [STATE_W-1:0] RESET_STATE = 6'h00;
    localparam logic [3:0] SEL_WARN = 4'h8;
    localparam logic [3:0] SEL_JUMP_ONLY = 4'h9;

    // driver output source select
    typedef enum logic [1:0] {SRC_FSM = 2'h0, SRC_HOST = 2'h1, SRC_CLK = 2'h2} ssq_src_t;

    typedef enum logic [1:0] {EXIT_NONE = 2'h0, EXIT_SEQ = 2'h1,
                              EXIT_TMO = 2'h2, EXIT_MON = 2'h3} ssq_exit_t;

    typedef struct packed {
        logic [NUM_DRV-1:0] drv_level;
        logic [3:0]         seq_sel;
        logic               seq_pol;
        logic [DLY_W-1:0]   seq_dly;
        logic [STATE_W-1:0] seq_next;
        logic [NUM_IN-1:0]  mon_mask;
        logic [NUM_IN-1:0]  mon_pol;
        logic               mon_warn;
        logic [STATE_W-1:0] mon_next;
        logic               tmo_en;
        logic [DLY_W-1:0]   tmo_dly;
        logic               tmo_warn;
        logic [STATE_W-1:0] tmo_next;
        logic               bbox_wr;
    } ssq_def_t;

    typedef struct packed {
        logic [STATE_W-1:0] prev_state;
        ssq_exit_t          cause;
        logic [NUM_IN-1:0]  status;
    } ssq_rec_t;
endpackage

// >>> rtl/ssq_sync.sv
`timescale 1ns/10ps
module ssq_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         CLK,   // system clock
    input  wire logic         RST_B, // async reset, low
    input  wire logic [W-1:0] D,     // async inputs
    output logic      [W-1:0] Q      // synchronised
);
    logic [W-1:0] s1_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s1_q <= '0;
            Q    <= '0;
        end else begin
            s1_q <= D;
            Q    <= s1_q;
        end
    end
endmodule

// >>> rtl/ssq_timer.sv
`timescale 1ns/10ps
module ssq_timer #(
    parameter int unsigned W = 16
) (
    input  wire logic         CLK,   // system clock
    input  wire logic         RST_B, // async reset, low
    input  wire logic         TICK,  // timebase pulse
    input  wire logic         LOAD,  // restart count
    input  wire logic [W-1:0] DLY,   // delay in ticks
    output logic              DONE   // delay elapsed
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_q <= '0;
        end else if (LOAD) begin
            cnt_q <= DLY;
        end else if (TICK && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign DONE = (cnt_q == '0) && !LOAD;
endmodule

// >>> sim/ssq_defstore.sv
`timescale 1ns/10ps
module ssq_defstore
    import ssq_pkg::*;
(
    input  wire logic               CLK,       // system clock
    input  wire logic               RST_B,     // async reset, low
    input  wire logic [STATE_W-1:0] DEF_ADDR,  // state to fetch
    input  wire logic               DEF_REQ,   // fetch request
    output logic                    DEF_VALID, // definition present
    output ssq_pkg::ssq_def_t       DEF_DATA   // definition
);
    // one definition per state number, loaded by the bench
    ssq_def_t mem [NUM_STATES];
    int       lat = 2;
    int       cnt;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            DEF_VALID <= 1'b0;
            DEF_DATA  <= '1;
            cnt       <= 0;
        end else if (!DEF_REQ || DEF_VALID) begin
            // bus not held: keep changing so stale data never looks valid
            DEF_VALID <= 1'b0;
            DEF_DATA  <= ~DEF_DATA;
            cnt       <= 0;
        end else if (cnt >= lat) begin
            DEF_VALID <= 1'b1;
            DEF_DATA  <= mem[DEF_ADDR];
        end else begin
            cnt       <= cnt + 1;
            DEF_DATA  <= ~DEF_DATA;
        end
    end
endmodule

// >>> sim/tb_ssq_engine.sv
`timescale 1ns/10ps
module tb_ssq_engine;
    import ssq_pkg::*;
    logic                   clk = 1'b0;
    logic                   rst_b = 1'b0;
    logic [2:0]             pos_ok = 3'h0;
    logic                   hv_ok = 1'b0;
    logic [3:0]             dual_in = 4'h0;
    logic                   lim_warn = 1'b0;
    logic [3:0]             sec_warn = 4'h0;
    logic                   jump = 1'b0;
    logic [STATE_W-1:0]     def_addr;
    logic [STATE_W-1:0]     cur_state;
    logic                   def_req;
    logic                   def_valid;
    logic                   bbox_wr;
    logic                   fetch_err;
    ssq_def_t               def_data;
    ssq_def_t               d;
    ssq_src_t [NUM_DRV-1:0] drv_src;
    logic [NUM_DRV-1:0]     drv_host = 8'h00;
    logic [NUM_DRV-1:0]     drv_out;
    ssq_rec_t               bbox_rec;
    ssq_rec_t               rec_seen;
    int                     err_count = 0;
    int                     total_checks = 0;
    int                     bb_count = 0;
    int                     n;
    logic                   b;

    always #2 clk = ~clk;

    ssq_defstore u_store (
        .CLK       (clk),
        .RST_B     (rst_b),
        .DEF_ADDR  (def_addr),
        .DEF_REQ   (def_req),
        .DEF_VALID (def_valid),
        .DEF_DATA  (def_data)
    );

    ssq_engine u_dut (
        .CLK           (clk),
        .RST_B         (rst_b),
        .POS_SUPPLY_OK (pos_ok),
        .HV_OK         (hv_ok),
        .DUAL_IN       (dual_in),
        .LIMIT_WARN    (lim_warn),
        .SEC_WARN      (sec_warn),
        .JUMP          (jump),
        .DEF_ADDR      (def_addr),
        .DEF_REQ       (def_req),
        .DEF_VALID     (def_valid),
        .DEF_DATA      (def_data),
        .DRV_SRC       (drv_src),
        .DRV_HOST      (drv_host),
        .DRIVER_OUTPUT (drv_out),
        .CUR_STATE     (cur_state),
        .BBOX_WR       (bbox_wr),
        .BBOX_REC      (bbox_rec),
        .FETCH_ERR     (fetch_err)
    );

    // record pulses sampled mid-cycle
    always @(negedge clk) begin
        if (bbox_wr === 1'b1) begin
            bb_count++;
            rec_seen = bbox_rec;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wait_state(input logic [STATE_W-1:0] st, input int maxc, output int cyc);
        cyc = 0;
        while (cur_state !== st && cyc < maxc) begin
            step(1);
            cyc++;
        end
        chk(cur_state, st);
    endtask

    function automatic ssq_def_t mk(input logic [7:0] lvl, input logic [3:0] sel,
                                    input logic pol, input int dly,
                                    input logic [STATE_W-1:0] nxt);
        ssq_def_t r;
        r = '0;
        r.drv_level = lvl;
        r.seq_sel = sel;
        r.seq_pol = pol;
        r.seq_dly = dly[DLY_W-1:0];
        r.seq_next = nxt;
        return r;
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end

    initial begin
        foreach (drv_src[i]) drv_src[i] = SRC_FSM;
        for (int i = 0; i < NUM_STATES; i++) u_store.mem[i] = '0;
        u_store.mem[0] = mk(8'h01, 4'h0, 1'b1, 0, 6'd62);
        u_store.mem[62] = mk(8'ha5, 4'h4, 1'b1, 4, 6'd5);
        d = mk(8'h3c, 4'h1, 1'b1, 0, 6'd9);
        d.tmo_en = 1'b1;
        d.tmo_dly = 16'h0002;
        d.tmo_next = 6'd7;
        u_store.mem[5] = d;
        d = mk(8'h04, 4'h3, 1'b0, 0, 6'd12);
        d.mon_mask = 8'h01;
        d.mon_pol = 8'h01;
        d.mon_next = 6'd11;
        d.bbox_wr = 1'b1;
        u_store.mem[7] = d;
        d = mk(8'h80, SEL_JUMP_ONLY, 1'b0, 0, 6'd14);
        d.mon_warn = 1'b1;
        d.mon_next = 6'd13;
        u_store.mem[11] = d;
        d.drv_level = 8'h40;
        u_store.mem[14] = d;
        u_store.mem[13] = mk(8'hff, SEL_JUMP_ONLY, 1'b0, 0, 6'd13);
        step(20);
        chk(def_req, 1'b1);
        chk(def_addr, 6'h00);
        chk(drv_out, 8'h00);
        rst_b = 1'b1;
        step(10);
        chk(cur_state, 6'h00);
        chk(drv_out, 8'h01);
        $display("test reset done");
        pos_ok = 3'h1;
        wait_state(6'd62, 100, n);
        chk(def_addr, 6'd62);
        step(5);
        chk(drv_out, 8'ha5);
        $display("test sequence exit done");
        dual_in = 4'h1;
        step(5000);
        dual_in = 4'h0;
        step(10);
        dual_in = 4'h1;
        step(5990);
        chk(cur_state, 6'd62);
        chk(drv_out, 8'ha5);
        u_store.lat = 40;
        wait_state(6'd5, 5000, n);
        step(50);
        chk(drv_out, 8'h3c);
        $display("test sequence delay done");
        u_store.lat = 2;
        pos_ok = 3'h0;
        step(2300);
        chk(cur_state, 6'd5);
        wait_state(6'd11, 3000, n);
        chk(bb_count, 1);
        chk(rec_seen.prev_state, 6'd5);
        chk(rec_seen.cause, EXIT_TMO);
        chk(rec_seen.status, 8'h10);
        $display("test timeout and priority done");
        step(5);
        jump = 1'b1;
        step(1);
        jump = 1'b0;
        wait_state(6'd14, 50, n);
        step(5);
        sec_warn = 4'h4;
        wait_state(6'd13, 8, n);
        sec_warn = 4'h0;
        $display("test jump and warning done");
        step(10);
        chk(drv_out, 8'hff);
        drv_src[0] = SRC_HOST;
        drv_src[1] = ssq_src_t'(2'h3);
        drv_src[2] = SRC_CLK;
        step(3);
        chk(drv_out[1:0], 2'b00);
        chk(drv_out[7:3], 5'h1f);
        drv_host = 8'h01;
        step(3);
        chk(drv_out[0], 1'b1);
        b = ~drv_out[2];
        step(CLK100K_HALF);
        chk(drv_out[2], b);
        chk(fetch_err, 1'b0);
        chk(bb_count, 1);
        $display("test output source done");
        report_and_stop();
    end
endmodule
